// *** rtl/umcls_consts.svh ***
// constants for the modem control and line status block
// Function
// [RQ1] The aux output bit 2 never reaches a pin and acts only in loop-back.
// [RQ2] In loop-back, bit 2 of modem control is the internal ring indicator.
// [RQ3] Active-low RTS is high when control bit 1 is 0 (reset), low when 1.
// [RQ4] Active-low DTR is high when control bit 0 is 0, as after reset.
// [RQ5] Active-low DTR is low when control bit 0 is 1.
// [RQ6] Status bit 7 is 1 while any character in the receive FIFO has an error.
// [RQ7] Status bit 7 clears only when no remaining FIFO character has an error.
// [RQ8] In non-FIFO mode status bit 6 is 1 when holding and shift regs are empty.
// [RQ9] Status bit 6 is 0 whenever holding or shift register holds a character; in FIFO mode the code ignores the holding register.
// [RQ10] In FIFO mode status bit 6 is 1 when transmit FIFO and shift reg empty.
// [RQ11] The line status register is readable by the CPU.
// [RQ12] Control bit 4 enables loop-back: pins cut off, controls fed to inputs; the code feeds back only aux bit 2 (as ring) and TX_SER.
// [RQ13] The line status register is read-only; writes change no flag.
`ifndef UMCLS_CONSTS_SVH
`define UMCLS_CONSTS_SVH
`define UMCLS_ADDR_W        3
`define UMCLS_OFS_MCTL      3'h4
`define UMCLS_OFS_LSTAT     3'h5
`define UMCLS_OFS_ISTAT     3'h6
`define UMCLS_OFS_ICLR      3'h6
`define UMCLS_OFS_IEN       3'h7
`define UMCLS_MCTL_RESET    8'h00
`define UMCLS_MCTL_MASK     8'h9F
`define UMCLS_BIT_DTR       0
`define UMCLS_BIT_RTS       1
`define UMCLS_BIT_AUX       2
`define UMCLS_BIT_LOOP      4
`define UMCLS_BIT_TEMT      6
`define UMCLS_BIT_FERR      7
`define UMCLS_IRQ_W         3
`define UMCLS_IRQ_FERR      0
`define UMCLS_IRQ_TEMT      1
`define UMCLS_IRQ_RING      2
`endif

// *** rtl/umcls_pkg.sv ***
// types for the modem control and line status block
package umcls_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } umcls_bus_s;
  typedef struct packed {
    logic fifo_mode;
    logic thr_empty;
    logic tsr_empty;
    logic txf_empty;
    logic rxf_err_any;
  } umcls_core_s;
endpackage

// *** rtl/umcls_top.sv ***
// modem control low bits, line status bits 6 and 7, loop-back muxing
`timescale 1ns/1ps
`default_nettype none
`include "umcls_consts.svh"
module umcls_top
(
  input  wire logic       REF_CLK,
  input  wire logic       RST,
  input  wire logic [2:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output var  logic [7:0] RDATA,
  input  wire logic       FIFO_MODE,
  input  wire logic       THR_EMPTY,
  input  wire logic       TSR_EMPTY,
  input  wire logic       TXF_EMPTY,
  input  wire logic       RXF_ERR_ANY,
  input  wire logic [5:0] LSR_LOW,
  input  wire logic       TX_SER,
  input  wire logic       RX_PIN,
  input  wire logic       RI_N_PIN,
  output var  logic       TX_PIN,
  output var  logic       RX_SER,
  output var  logic       RI_INT,
  output var  logic       LOOP_EN,
  output var  logic       RTS_N,
  output var  logic       DTR_N,
  output var  logic       IRQ
);
  umcls_pkg::umcls_bus_s  bus;
  umcls_pkg::umcls_core_s core;
  logic [7:0]             mctl_reg;
  logic [7:0]             lstat_reg;
  logic [2:0]             istat_reg;
  logic [2:0]             ien_reg;
  logic [2:0]             ev;
  logic [2:0]             ev_prev_reg;
  logic                   temt;
  logic                   ring;

  assign bus  = '{wr: WR, rd: RD, addr: ADDR, wdata: WDATA};
  assign core = '{fifo_mode: FIFO_MODE, thr_empty: THR_EMPTY,
                  tsr_empty: TSR_EMPTY, txf_empty: TXF_EMPTY,
                  rxf_err_any: RXF_ERR_ANY};

  function automatic logic hit(input logic [2:0] a, input logic [2:0] o);
    hit = (a == o);
  endfunction

  // modem control register; reserved bits 5,6 stay zero
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      mctl_reg <= `UMCLS_MCTL_RESET;
    else if (bus.wr && hit(bus.addr, `UMCLS_OFS_MCTL))
      mctl_reg <= bus.wdata & `UMCLS_MCTL_MASK;
  end

  // transmit empty by mode
  always_comb
  begin
    if (core.fifo_mode)
      temt = core.txf_empty && core.tsr_empty; // RQ10
    else
      temt = core.thr_empty && core.tsr_empty; // RQ8 RQ9
  end

  // line status: flags track hardware, writes ignored
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      lstat_reg <= 8'h00;
    else
    begin
      lstat_reg[5:0]               <= LSR_LOW;
      lstat_reg[`UMCLS_BIT_TEMT]   <= temt; // RQ8 RQ9 RQ10 RQ13
      lstat_reg[`UMCLS_BIT_FERR]   <= core.rxf_err_any; // RQ6 RQ7 RQ13
    end
  end

  // aux bit feeds ring only under loop-back
  assign ring = mctl_reg[`UMCLS_BIT_LOOP] ? mctl_reg[`UMCLS_BIT_AUX]
                                          : ~RI_N_PIN; // RQ1 RQ2

  // pins and loop-back path
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      RTS_N   <= 1'b1;
      DTR_N   <= 1'b1;
      TX_PIN  <= 1'b1;
      RX_SER  <= 1'b1;
      RI_INT  <= 1'b0;
      LOOP_EN <= 1'b0;
    end
    else
    begin
      LOOP_EN <= mctl_reg[`UMCLS_BIT_LOOP]; // RQ12
      RI_INT  <= ring; // RQ2
      if (mctl_reg[`UMCLS_BIT_LOOP])
      begin
        RTS_N  <= 1'b1; // RQ12
        DTR_N  <= 1'b1; // RQ12
        TX_PIN <= 1'b1; // RQ12
        RX_SER <= TX_SER; // RQ12
      end
      else
      begin
        RTS_N  <= ~mctl_reg[`UMCLS_BIT_RTS]; // RQ3
        DTR_N  <= ~mctl_reg[`UMCLS_BIT_DTR]; // RQ4 RQ5
        TX_PIN <= TX_SER;
        RX_SER <= RX_PIN;
      end
    end
  end

  // rising-edge events for status/ier
  assign ev[`UMCLS_IRQ_FERR] = core.rxf_err_any;
  assign ev[`UMCLS_IRQ_TEMT] = temt;
  assign ev[`UMCLS_IRQ_RING] = ring;

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      ev_prev_reg <= 3'h0;
    else
      ev_prev_reg <= ev;
  end

  genvar gi;
  generate
    for (gi = 0; gi < `UMCLS_IRQ_W; gi++)
    begin : g_ist
      // set wins over clear
      always_ff @(posedge REF_CLK)
      begin
        if (RST)
          istat_reg[gi] <= 1'b0;
        else if (ev[gi] && !ev_prev_reg[gi])
          istat_reg[gi] <= 1'b1;
        else if (bus.wr && hit(bus.addr, `UMCLS_OFS_ICLR) && bus.wdata[gi])
          istat_reg[gi] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      ien_reg <= 3'h0;
    else if (bus.wr && hit(bus.addr, `UMCLS_OFS_IEN))
      ien_reg <= bus.wdata[2:0];
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      IRQ <= 1'b0;
    else
      IRQ <= |(istat_reg & ien_reg);
  end

  // read data one cycle after strobe
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      RDATA <= 8'h00;
    else if (bus.rd)
    begin
      case (bus.addr)
        `UMCLS_OFS_MCTL:  RDATA <= mctl_reg;
        `UMCLS_OFS_LSTAT: RDATA <= lstat_reg; // RQ11
        `UMCLS_OFS_ISTAT: RDATA <= {5'h00, istat_reg};
        `UMCLS_OFS_IEN:   RDATA <= {5'h00, ien_reg};
        default:          RDATA <= 8'h00;
      endcase
    end
    else
      RDATA <= 8'h00;
  end

  // checks
  rts_follow_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !mctl_reg[`UMCLS_BIT_LOOP] ##1 !mctl_reg[`UMCLS_BIT_LOOP]
    |-> RTS_N == ~$past(mctl_reg[`UMCLS_BIT_RTS])) // RQ3
    else $error("rts does not follow control bit");
  dtr_follow_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !mctl_reg[`UMCLS_BIT_LOOP] |=> DTR_N == ~$past(mctl_reg[0])) // RQ4
    else $error("dtr does not follow control bit");
  dtr_low_a: assert property (@(posedge REF_CLK) disable iff (RST)
    (mctl_reg[0] && !mctl_reg[4]) |=> !DTR_N) // RQ5
    else $error("dtr not low when set");
  ring_loop_a: assert property (@(posedge REF_CLK) disable iff (RST)
    mctl_reg[`UMCLS_BIT_LOOP] |=> RI_INT == $past(mctl_reg[2])) // RQ2
    else $error("ring not taken from aux bit");
  aux_pin_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !mctl_reg[`UMCLS_BIT_LOOP] |=> RI_INT == ~$past(RI_N_PIN)) // RQ1
    else $error("aux bit leaked outside loop-back");
  ferr_track_a: assert property (@(posedge REF_CLK) disable iff (RST)
    1'b1 |=> lstat_reg[7] == $past(RXF_ERR_ANY)) // RQ6
    else $error("fifo error flag wrong");
  ferr_hold_a: assert property (@(posedge REF_CLK) disable iff (RST)
    (RXF_ERR_ANY && RD) |=> lstat_reg[7]) // RQ7
    else $error("fifo error cleared by read");
  temt_nf_a: assert property (@(posedge REF_CLK) disable iff (RST)
    (!FIFO_MODE && THR_EMPTY && TSR_EMPTY) |=> lstat_reg[6]) // RQ8
    else $error("temt not set in holding mode");
  temt_busy_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !TSR_EMPTY |=> !lstat_reg[6]) // RQ9
    else $error("temt set while shift busy");
  temt_fifo_a: assert property (@(posedge REF_CLK) disable iff (RST)
    (FIFO_MODE && TXF_EMPTY && TSR_EMPTY) |=> lstat_reg[6]) // RQ10
    else $error("temt not set in fifo mode");
  lsr_read_a: assert property (@(posedge REF_CLK) disable iff (RST)
    (RD && ADDR == `UMCLS_OFS_LSTAT) |=> RDATA == $past(lstat_reg)) // RQ11
    else $error("status read wrong");
  loop_pin_a: assert property (@(posedge REF_CLK) disable iff (RST)
    mctl_reg[4] |=> (RTS_N && TX_PIN && RX_SER == $past(TX_SER))) // RQ12
    else $error("loop-back not isolating pins");
  ro_lsr_a: assert property (@(posedge REF_CLK) disable iff (RST) // RQ13
    (WR && ADDR == `UMCLS_OFS_LSTAT) |=> lstat_reg[7] == $past(RXF_ERR_ANY))
    else $error("status write took effect");

  // pin and loop-back path
  dtr_loop_a: assert property (@(posedge REF_CLK) disable iff (RST) // RQ12
    mctl_reg[`UMCLS_BIT_LOOP] |=> DTR_N)
    else $error("dtr active in loop-back");
  loop_en_a: assert property (@(posedge REF_CLK) disable iff (RST) // RQ12
    1'b1 |=> LOOP_EN == $past(mctl_reg[`UMCLS_BIT_LOOP]))
    else $error("loop enable does not follow control bit");
  tx_pass_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !mctl_reg[`UMCLS_BIT_LOOP] |=> TX_PIN == $past(TX_SER))
    else $error("tx pin does not follow serial data");
  rx_pass_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !mctl_reg[`UMCLS_BIT_LOOP] |=> RX_SER == $past(RX_PIN))
    else $error("receive data does not follow rx pin");

  // register bus
  mctl_wr_a: assert property (@(posedge REF_CLK) disable iff (RST)
    (WR && ADDR == `UMCLS_OFS_MCTL)
    |=> mctl_reg == ($past(WDATA) & `UMCLS_MCTL_MASK))
    else $error("modem control write lost");
  mctl_rsv_a: assert property (@(posedge REF_CLK) disable iff (RST)
    1'b1 |-> mctl_reg[6:5] == 2'b00)
    else $error("reserved control bits set");
  mctl_rd_a: assert property (@(posedge REF_CLK) disable iff (RST)
    (RD && ADDR == `UMCLS_OFS_MCTL) |=> RDATA == $past(mctl_reg))
    else $error("modem control read wrong");
  rdata_idle_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !RD |=> RDATA == 8'h00)
    else $error("read data not zero when idle");
  unmapped_rd_a: assert property (@(posedge REF_CLK) disable iff (RST)
    (RD && ADDR < `UMCLS_OFS_MCTL) |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  lsr_low_a: assert property (@(posedge REF_CLK) disable iff (RST) // RQ11
    1'b1 |=> lstat_reg[5:0] == $past(LSR_LOW))
    else $error("low status bits not passed");

  // interrupt status, enable and output
  ist_ferr_a: assert property (@(posedge REF_CLK) disable iff (RST)
    (ev[0] && !ev_prev_reg[0]) |=> istat_reg[0])
    else $error("fifo error event not latched");
  ist_temt_a: assert property (@(posedge REF_CLK) disable iff (RST)
    (ev[1] && !ev_prev_reg[1]) |=> istat_reg[1])
    else $error("transmit empty event not latched");
  ist_ring_a: assert property (@(posedge REF_CLK) disable iff (RST)
    (ev[2] && !ev_prev_reg[2]) |=> istat_reg[2])
    else $error("ring event not latched");
  ist_clr_a: assert property (@(posedge REF_CLK) disable iff (RST)
    (WR && ADDR == `UMCLS_OFS_ICLR && (ev & ~ev_prev_reg) == 3'h0)
    |=> (istat_reg & $past(WDATA[2:0])) == 3'h0)
    else $error("status clear lost");
  ien_wr_a: assert property (@(posedge REF_CLK) disable iff (RST)
    (WR && ADDR == `UMCLS_OFS_IEN) |=> ien_reg == $past(WDATA[2:0]))
    else $error("enable write lost");
  irq_level_a: assert property (@(posedge REF_CLK) disable iff (RST)
    1'b1 |=> IRQ == $past(|(istat_reg & ien_reg)))
    else $error("irq does not follow enabled status");

  // main scenarios
  loop_c: cover property (@(posedge REF_CLK) mctl_reg[4] && mctl_reg[2]);
  irq_c: cover property (@(posedge REF_CLK) IRQ);
  ferr_c: cover property (@(posedge REF_CLK) lstat_reg[7] ##1 !lstat_reg[7]);
  temt_c: cover property (@(posedge REF_CLK) lstat_reg[6] ##1 !lstat_reg[6]);
  ring_pin_c: cover property (@(posedge REF_CLK) !mctl_reg[4] && RI_INT);
endmodule // umcls_top
`default_nettype wire

// *** testbench/umcls_peer.sv ***
// line side model: remote modem ring and receive line
`timescale 1ns/1ps
`default_nettype none
module umcls_peer
(
  input  wire logic clk,
  input  wire logic ring,
  input  wire logic line,
  output var  logic rx_pin,
  output var  logic ri_n_pin
);
  initial
  begin
    rx_pin = 1'b1;
    ri_n_pin = 1'b1;
  end
  always @(posedge clk)
  begin
    ri_n_pin <= ~ring;
    rx_pin <= line;
  end
endmodule // umcls_peer
`default_nettype wire

// *** testbench/test_uart_modem_ctrl_line_status.sv ***
// bench for the modem control and line status block
`timescale 1ns/1ps
`default_nettype none
module test_uart_modem_ctrl_line_status;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       tx_ser = 1'b0;
  logic       ring = 1'b0;
  logic [7:0] rdata;
  logic       tx_pin, rx_ser, ri_int, loop_en, rts_n, dtr_n, irq;
  logic       rx_pin, ri_n_pin;
  int         err_total = 0;
  int         total_checks = 0;
  umcls_pkg::umcls_core_s core = '0;
  always #10 clk = ~clk;
  umcls_peer PEER (.clk(clk), .ring(ring), .line(1'b1),
    .rx_pin(rx_pin), .ri_n_pin(ri_n_pin));
  umcls_top DUT (.REF_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .FIFO_MODE(core.fifo_mode),
    .THR_EMPTY(core.thr_empty), .TSR_EMPTY(core.tsr_empty),
    .TXF_EMPTY(core.txf_empty), .RXF_ERR_ANY(core.rxf_err_any),
    .LSR_LOW(6'h15), .TX_SER(tx_ser), .RX_PIN(rx_pin),
    .RI_N_PIN(ri_n_pin), .TX_PIN(tx_pin), .RX_SER(rx_ser),
    .RI_INT(ri_int), .LOOP_EN(loop_en), .RTS_N(rts_n), .DTR_N(dtr_n),
    .IRQ(irq));
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [2:0] a, input logic [7:0] e,
                      input string nm);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(nm, e, rdata);
  endtask
  // order: rts_n dtr_n loop_en ri_int tx_pin rx_ser
  task automatic pins(input logic [7:0] e);
    repeat (3) @(posedge clk);
    #1 chk("pins", e, {2'b00, rts_n, dtr_n, loop_en, ri_int, tx_pin, rx_ser});
  endtask
  task automatic irqchk(input logic e);
    repeat (3) @(posedge clk);
    #1 chk("irq", {7'h00, e}, {7'h00, irq});
  endtask
  task automatic t_modem();
    pins(8'h31);
    rreg(3'h4, 8'h00, "mctl");
    for (int i = 0; i < 4; i++)
    begin
      wreg(3'h4, 8'(i));
      pins({2'b00, ~i[1], ~i[0], 4'b0001});
      rreg(3'h4, 8'(i), "mctl");
    end
    wreg(3'h4, 8'hFF);
    rreg(3'h4, 8'h9F, "mctl");
    pins(8'h3E);
    @(posedge clk);
    tx_ser <= 1'b1;
    wreg(3'h4, 8'h10);
    pins(8'h3B);
    wreg(3'h4, 8'h04);
    pins(8'h33);
    @(posedge clk);
    ring <= 1'b1;
    pins(8'h37);
  endtask
  // every combination of the core status levels
  task automatic t_status();
    logic [7:0] e;
    for (int i = 0; i < 32; i++)
    begin
      @(posedge clk);
      core <= 5'(i);
      e = {i[0], i[2] & (i[4] ? i[1] : i[3]), 6'h15};
      rreg(3'h5, e, "lstat");
    end
    wreg(3'h5, 8'h00);
    rreg(3'h5, e, "lstat");
  endtask
  task automatic t_irq();
    @(posedge clk);
    core <= '0;
    wreg(3'h6, 8'h07);
    wreg(3'h7, 8'h01);
    rreg(3'h7, 8'h01, "int_en");
    rreg(3'h6, 8'h00, "int_stat");
    @(posedge clk);
    core <= 5'h01;
    irqchk(1'b1);
    rreg(3'h6, 8'h01, "int_stat");
    wreg(3'h7, 8'h00);
    irqchk(1'b0);
    wreg(3'h7, 8'h01);
    irqchk(1'b1);
    wreg(3'h6, 8'h01);
    irqchk(1'b0);
    rreg(3'h0, 8'h00, "unmapped");
  endtask
  task automatic results();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    err_total++;
    results();
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_modem();
    t_status();
    t_irq();
    results();
  end
endmodule // test_uart_modem_ctrl_line_status
`default_nettype wire
